// file: pkg/wlr_consts.svh
`ifndef WLR_CONSTS_SVH
`define WLR_CONSTS_SVH

// ----------------------------------------
// Parameter addresses
// ----------------------------------------
`define WLR_ADDR_ABS_CFG    16'h062C
`define WLR_ADDR_PRESENT    16'h1C16
`define WLR_ADDR_SAVED      16'h1C18

// ----------------------------------------
// Bit positions of the warning words
// ----------------------------------------
`define WLR_BIT_GENERAL     0
`define WLR_BIT_STAGE_TEMP  1
`define WLR_BIT_MOTOR_TEMP  2
`define WLR_BIT_RSVD_LO     3
`define WLR_BIT_STAGE_OVL   4
`define WLR_BIT_MOTOR_OVL   5
`define WLR_BIT_BRAKE_OVL   6
`define WLR_BIT_CAN         7
`define WLR_BIT_ENCODER     8
`define WLR_BIT_RS485       9
`define WLR_BIT_STO         10
`define WLR_BIT_UNDERVOLT   11
`define WLR_BIT_ALT_BUS     12
`define WLR_BIT_CAPTURE     13
`define WLR_BIT_ETHERNET    14
`define WLR_BIT_RSVD_HI     15

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define WLR_AUTO_CLEAR_MASK 16'h2C00
`define WLR_RESERVED_MASK   16'h8008
`define WLR_ABS_CFG_RESET   1'h0
`define WLR_WORD_RESET      16'h0000

`endif

// file: pkg/wlr_pkg.sv
package wlr_pkg;

	// Raw warning causes from the drive's monitors
	typedef struct packed {
		logic ethernet;
		logic capture_busy;
		logic alt_bus;
		logic phase_loss;
		logic undervolt;
		logic safe_torque_off_b;
		logic safe_torque_off_a;
		logic rs485;
		logic encoder;
		logic can;
		logic brake_ovl;
		logic motor_ovl;
		logic stage_ovl;
		logic motor_temp;
		logic stage_temp;
		logic general;
	} wlr_cause_t;

	// Parameter access request
	typedef struct packed {
		logic        rd_en;
		logic        wr_en;
		logic [15:0] addr;
		logic [15:0] wdata;
	} wlr_req_t;

	// Absolute move answer
	typedef struct packed {
		logic granted;
		logic refused;
	} wlr_move_ans_t;

endpackage : wlr_pkg

// file: rtl/wlr_warning_latch.sv
`include "wlr_consts.svh"

// Operation
// RULE_01: Keep a 16-bit saved warning word, one=activated.
// RULE_02: Live word uses the same bit layout.
// RULE_03: Fault clear command clears all saved bits; code keeps bits whose live bit is still set.
// RULE_04: Bits 10, 11, 13 clear by themselves.
// RULE_05: Bit 0 general; code kept separately.
// RULE_06: Bit 1 stage temp, bit 2 motor temp.
// RULE_07: Bits 4-6 overloads of stage, motor, resistor.
// RULE_08: Bit 8 flags motor encoder warning.
// RULE_09: Bit 7 CAN, 9 RS485, 12 alternative fieldbus.
// RULE_10: Bit 14 flags Ethernet warning.
// RULE_11: Bit 10 flags either safe torque off input.
// RULE_12: Bit 11 undervoltage or missing mains phase.
// RULE_13: Bit 13 position capture still running.
// RULE_14: Absolute moves refused before homing when flag set.
// RULE_15: Live warning word readable at its address.
// RULE_16: Saved bit set by live bit, held.
// RULE_17: Reserved bits 3 and 15 read zero.
module wlr_warning_latch (
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_i,
	input  wire wlr_pkg::wlr_cause_t   cause_i,
	input  wire logic [15:0]           warn_code_i,
	input  wire logic                  fault_clear_command_i,
	input  wire wlr_pkg::wlr_req_t     req_i,
	input  wire logic                  homing_done_i,
	input  wire logic                  abs_move_req_i,
	output logic [15:0]                rd_data_o,
	output logic                       rd_valid_o,
	output logic                       access_err_o,
	output logic [15:0]                saved_warning_bits_o,
	output logic [15:0]                most_recent_warning_code_o,
	output wlr_pkg::wlr_move_ans_t     move_ans_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Causes come from pins and other monitors, so all are synchronised
	wlr_pkg::wlr_cause_t sync1_q;
	wlr_pkg::wlr_cause_t sync2_q;
	wlr_pkg::wlr_cause_t sync1_d;
	wlr_pkg::wlr_cause_t sync2_d;

	always_comb begin
		sync1_d = cause_i;
		sync2_d = sync1_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ----------------------------------------
	// Live warning word
	// ----------------------------------------
	function automatic logic [15:0] build_word(input wlr_pkg::wlr_cause_t c);
		logic [15:0] w;
		w = `WLR_WORD_RESET;
		w[`WLR_BIT_GENERAL]    = c.general;                  // see RULE_05
		w[`WLR_BIT_STAGE_TEMP] = c.stage_temp;               // see RULE_06
		w[`WLR_BIT_MOTOR_TEMP] = c.motor_temp;               // see RULE_06
		w[`WLR_BIT_STAGE_OVL]  = c.stage_ovl;                // see RULE_07
		w[`WLR_BIT_MOTOR_OVL]  = c.motor_ovl;                // see RULE_07
		w[`WLR_BIT_BRAKE_OVL]  = c.brake_ovl;                // see RULE_07
		w[`WLR_BIT_CAN]        = c.can;                      // see RULE_09
		w[`WLR_BIT_ENCODER]    = c.encoder;                  // see RULE_08
		w[`WLR_BIT_RS485]      = c.rs485;                    // see RULE_09
		w[`WLR_BIT_STO]        = c.safe_torque_off_a | c.safe_torque_off_b;          // see RULE_11
		w[`WLR_BIT_UNDERVOLT]  = c.undervolt | c.phase_loss; // see RULE_12
		w[`WLR_BIT_ALT_BUS]    = c.alt_bus;                  // see RULE_09
		w[`WLR_BIT_CAPTURE]    = c.capture_busy;             // see RULE_13
		w[`WLR_BIT_ETHERNET]   = c.ethernet;                 // see RULE_10
		return w & ~`WLR_RESERVED_MASK;                      // see RULE_17
	endfunction : build_word

	logic [15:0] present_q;
	logic [15:0] present_d;
	logic [15:0] saved_q;
	logic [15:0] saved_d;
	logic [15:0] code_q;
	logic [15:0] code_d;

	// ----------------------------------------
	// Saved warning word
	// ----------------------------------------
	always_comb begin
		present_d = build_word(sync2_q); // see RULE_02
		// Live bits win over a clear in the same cycle
		if (fault_clear_command_i) begin
			saved_d = present_q; // see RULE_03
		end else begin
			saved_d = saved_q | present_q; // see RULE_16
		end
		// Self-clearing bits simply follow their cause
		saved_d = (saved_d & ~`WLR_AUTO_CLEAR_MASK)
			| (present_q & `WLR_AUTO_CLEAR_MASK); // see RULE_04
		saved_d = saved_d & ~`WLR_RESERVED_MASK; // see RULE_17
		if (present_q[`WLR_BIT_GENERAL]) begin
			code_d = warn_code_i; // see RULE_05
		end else begin
			code_d = code_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			present_q <= `WLR_WORD_RESET;
			saved_q   <= `WLR_WORD_RESET;
			code_q    <= `WLR_WORD_RESET;
		end else begin
			present_q <= present_d;
			saved_q   <= saved_d; // see RULE_01
			code_q    <= code_d;
		end
	end

	// ----------------------------------------
	// Parameter access
	// ----------------------------------------
	logic        abs_cfg_q;
	logic        abs_cfg_d;
	logic [15:0] rd_data_q;
	logic [15:0] rd_data_d;
	logic        rd_valid_q;
	logic        rd_valid_d;
	logic        err_q;
	logic        err_d;

	always_comb begin
		abs_cfg_d  = abs_cfg_q;
		rd_data_d  = `WLR_WORD_RESET;
		rd_valid_d = 1'b0;
		err_d      = 1'b0;
		if (req_i.rd_en) begin
			rd_valid_d = 1'b1;
			unique case (req_i.addr)
				`WLR_ADDR_ABS_CFG: rd_data_d = {15'h0000, abs_cfg_q};
				`WLR_ADDR_PRESENT: rd_data_d = present_q; // see RULE_15
				`WLR_ADDR_SAVED:   rd_data_d = saved_q;   // see RULE_01
				default:           err_d     = 1'b1;
			endcase
		end else if (req_i.wr_en) begin
			// Only the config accepts writes, and only 0 or 1
			if (req_i.addr == `WLR_ADDR_ABS_CFG && req_i.wdata[15:1] == 15'h0000) begin
				abs_cfg_d = req_i.wdata[0];
			end else begin
				err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			abs_cfg_q  <= `WLR_ABS_CFG_RESET;
			rd_data_q  <= `WLR_WORD_RESET;
			rd_valid_q <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			abs_cfg_q  <= abs_cfg_d;
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			err_q      <= err_d;
		end
	end

	// ----------------------------------------
	// Absolute move gate
	// ----------------------------------------
	wlr_pkg::wlr_move_ans_t move_q;
	wlr_pkg::wlr_move_ans_t move_d;

	always_comb begin
		move_d = '0;
		if (abs_move_req_i) begin
			if (abs_cfg_q && !homing_done_i) begin
				move_d.refused = 1'b1; // see RULE_14
			end else begin
				move_d.granted = 1'b1; // see RULE_14
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			move_q <= '0;
		end else begin
			move_q <= move_d;
		end
	end

	assign rd_data_o                  = rd_data_q;
	assign rd_valid_o                 = rd_valid_q;
	assign access_err_o               = err_q;
	assign saved_warning_bits_o       = saved_q;
	assign most_recent_warning_code_o = code_q;
	assign move_ans_o                 = move_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	property p_reserved_zero;
		saved_q[`WLR_BIT_RSVD_LO] == 1'b0 && saved_q[`WLR_BIT_RSVD_HI] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // see RULE_17
		else $error("reserved saved bit set");

	property p_latch_set;
		$rose(present_q[`WLR_BIT_MOTOR_OVL]) |=> saved_q[`WLR_BIT_MOTOR_OVL];
	endproperty
	a_latch_set: assert property (p_latch_set) // see RULE_16
		else $error("saved bit not set by live bit");

	property p_latch_hold;
		saved_q[`WLR_BIT_ENCODER] && !fault_clear_command_i |=> saved_q[`WLR_BIT_ENCODER];
	endproperty
	a_latch_hold: assert property (p_latch_hold) // see RULE_01
		else $error("saved bit lost without clear");

	property p_fault_clear;
		fault_clear_command_i && present_q == 16'h0000 |=> saved_q == 16'h0000;
	endproperty
	a_fault_clear: assert property (p_fault_clear) // see RULE_03
		else $error("fault clear left saved bits");

	property p_auto_clear;
		!present_q[`WLR_BIT_CAPTURE] && !present_q[`WLR_BIT_UNDERVOLT]
			|=> !saved_q[`WLR_BIT_CAPTURE] && !saved_q[`WLR_BIT_UNDERVOLT];
	endproperty
	a_auto_clear: assert property (p_auto_clear) // see RULE_04
		else $error("self-clearing bit stuck");

	sequence s_safe_torque_off_a_held;
		cause_i.safe_torque_off_a [*3];
	endsequence

	property p_sto_reaches_word;
		s_safe_torque_off_a_held |=> present_q[`WLR_BIT_STO] ##1 saved_q[`WLR_BIT_STO];
	endproperty
	a_sto_reaches_word: assert property (p_sto_reaches_word) // see RULE_11
		else $error("safe torque off not flagged");

	sequence s_move_req_blocked;
		abs_move_req_i && abs_cfg_q && !homing_done_i;
	endsequence

	property p_move_refused;
		s_move_req_blocked |=> move_ans_o.refused && !move_ans_o.granted;
	endproperty
	a_move_refused: assert property (p_move_refused) // see RULE_14
		else $error("absolute move not refused");

	property p_move_free;
		abs_move_req_i && !abs_cfg_q |=> move_ans_o.granted && !move_ans_o.refused;
	endproperty
	a_move_free: assert property (p_move_free) // see RULE_14
		else $error("absolute move not granted");

	property p_read_saved;
		req_i.rd_en && req_i.addr == `WLR_ADDR_SAVED |=> rd_valid_o && rd_data_o == $past(saved_q);
	endproperty
	a_read_saved: assert property (p_read_saved) // see RULE_01
		else $error("saved word read mismatch");

	property p_read_present;
		req_i.rd_en && req_i.addr == `WLR_ADDR_PRESENT |=> rd_data_o == $past(present_q);
	endproperty
	a_read_present: assert property (p_read_present) // see RULE_15
		else $error("live word read mismatch");

	property p_code_capture;
		present_q[`WLR_BIT_GENERAL] |=> most_recent_warning_code_o == $past(warn_code_i);
	endproperty
	a_code_capture: assert property (p_code_capture) // see RULE_05
		else $error("warning code not captured");

	property p_code_hold;
		!present_q[`WLR_BIT_GENERAL] |=> most_recent_warning_code_o == $past(code_q);
	endproperty
	a_code_hold: assert property (p_code_hold) // see RULE_05
		else $error("warning code changed without warning");

	property p_clear_set_wins;
		fault_clear_command_i && present_q[`WLR_BIT_ENCODER] |=> saved_q[`WLR_BIT_ENCODER];
	endproperty
	a_clear_set_wins: assert property (p_clear_set_wins) // see RULE_03
		else $error("fault clear dropped a live bit");

	property p_saved_read_only;
		req_i.wr_en && !req_i.rd_en && req_i.addr == `WLR_ADDR_SAVED |=> access_err_o;
	endproperty
	a_saved_read_only: assert property (p_saved_read_only) // see RULE_01
		else $error("write to saved word not refused");

	property p_cfg_write;
		req_i.wr_en && !req_i.rd_en && req_i.addr == `WLR_ADDR_ABS_CFG && req_i.wdata[15:1] == 15'h0000
			|=> abs_cfg_q == $past(req_i.wdata[0]) && !access_err_o;
	endproperty
	a_cfg_write: assert property (p_cfg_write) // see RULE_14
		else $error("homing config write not taken");

endmodule : wlr_warning_latch

// file: tb/warning_latch_register_tb.sv
`include "wlr_consts.svh"

module warning_latch_register_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   clk_sys_i             = 1'b0;
	logic                   reset_i               = 1'b1;
	wlr_pkg::wlr_cause_t    cause_i               = '0;
	logic                   fault_clear_command_i = 1'b0;
	logic                   homing_done_i         = 1'b0;
	logic                   abs_move_req_i        = 1'b0;
	logic [15:0]            warn_code             = 16'h00A5;
	wlr_pkg::wlr_req_t      req;
	wlr_pkg::wlr_move_ans_t move_ans;
	logic [15:0]            rd_data;
	logic [15:0]            saved;
	logic [15:0]            code;
	logic                   rd_valid;
	logic                   access_err;
	logic [15:0]            exp_w;
	int                     error_cnt  = 0;
	int                     num_checks = 0;
	// Cause field index to word bit; two causes share bits 10 and 11
	int                     map [16]   = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 10, 10, 11, 11, 12, 13, 14};

	always #50 clk_sys_i = ~clk_sys_i;

	wlr_warning_latch uut (
		.clk_sys_i                  (clk_sys_i),
		.reset_i                    (reset_i),
		.cause_i                    (cause_i),
		.warn_code_i                (warn_code),
		.fault_clear_command_i      (fault_clear_command_i),
		.req_i                      (req),
		.homing_done_i              (homing_done_i),
		.abs_move_req_i             (abs_move_req_i),
		.rd_data_o                  (rd_data),
		.rd_valid_o                 (rd_valid),
		.access_err_o               (access_err),
		.saved_warning_bits_o       (saved),
		.most_recent_warning_code_o (code),
		.move_ans_o                 (move_ans)
	);

	wlr_bus_master bm (
		.clk_sys_i    (clk_sys_i),
		.rd_data_i    (rd_data),
		.rd_valid_i   (rd_valid),
		.access_err_i (access_err),
		.req_o        (req)
	);

	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick

	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] wd,
			input logic [15:0] exp_d, input logic exp_err);
		logic [15:0] d;
		logic        v;
		logic        e;
		bm.access(wr, a, wd, d, v, e);
		chk({15'h0000, e}, {15'h0000, exp_err});
		chk({15'h0000, v}, {15'h0000, ~wr});
		if (!wr) chk(d, exp_d);
	endtask : acc

	// Expected answer is {granted, refused}
	task automatic move(input logic [1:0] exp);
		@(posedge clk_sys_i);
		abs_move_req_i <= 1'b1;
		@(posedge clk_sys_i);
		abs_move_req_i <= 1'b0;
		@(posedge clk_sys_i);
		chk({14'h0000, move_ans}, {14'h0000, exp});
	endtask : move

	initial begin
		tick(8);
		reset_i <= 1'b0;
		acc(1'b0, `WLR_ADDR_SAVED, 16'h0000, 16'h0000, 1'b0);
		acc(1'b0, `WLR_ADDR_ABS_CFG, 16'h0000, 16'h0000, 1'b0);
		for (int i = 0; i < 16; i++) begin
			exp_w = 16'h0001 << map[i];
			cause_i <= wlr_pkg::wlr_cause_t'(16'h0001 << i);
			tick(5);
			acc(1'b0, `WLR_ADDR_PRESENT, 16'h0000, exp_w, 1'b0);
			acc(1'b0, `WLR_ADDR_SAVED, 16'h0000, exp_w, 1'b0);
			if (i == 0) chk(code, 16'h00A5);
			cause_i <= '0;
			tick(5);
			chk(saved, (|(exp_w & `WLR_AUTO_CLEAR_MASK)) ? 16'h0000 : exp_w);
			// New code while no general warning must not be taken
			if (i == 0) warn_code <= 16'h005A;
			fault_clear_command_i <= 1'b1;
			tick(1);
			fault_clear_command_i <= 1'b0;
			tick(2);
			chk(saved, 16'h0000);
			if (i == 0) chk(code, 16'h00A5);
		end
		// Clear while the cause is still live: the bit must survive
		cause_i.encoder <= 1'b1;
		tick(5);
		fault_clear_command_i <= 1'b1;
		tick(1);
		fault_clear_command_i <= 1'b0;
		tick(2);
		chk(saved, 16'h0100);
		cause_i <= '0;
		tick(5);
		chk(saved, 16'h0100);
		fault_clear_command_i <= 1'b1;
		tick(1);
		fault_clear_command_i <= 1'b0;
		tick(2);
		chk(saved, 16'h0000);
		acc(1'b1, `WLR_ADDR_ABS_CFG, 16'h0001, 16'h0000, 1'b0);
		acc(1'b1, `WLR_ADDR_ABS_CFG, 16'h0002, 16'h0000, 1'b1);
		acc(1'b1, `WLR_ADDR_SAVED, 16'hFFFF, 16'h0000, 1'b1);
		acc(1'b0, 16'h0001, 16'h0000, 16'h0000, 1'b1);
		acc(1'b0, `WLR_ADDR_ABS_CFG, 16'h0000, 16'h0001, 1'b0);
		move(2'b01);
		homing_done_i <= 1'b1;
		move(2'b10);
		homing_done_i <= 1'b0;
		acc(1'b1, `WLR_ADDR_ABS_CFG, 16'h0000, 16'h0000, 1'b0);
		move(2'b10);
		stop_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		tick(5000);
		error_cnt++;
		stop_test();
	end
endmodule : warning_latch_register_tb

// file: tb/wlr_bus_master.sv
// ----------------------------------------
// Fieldbus master issuing parameter accesses
// ----------------------------------------
module wlr_bus_master (
	input  wire logic        clk_sys_i,
	input  wire logic [15:0] rd_data_i,
	input  wire logic        rd_valid_i,
	input  wire logic        access_err_i,
	output wlr_pkg::wlr_req_t req_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial req_o = '0;

	// Released bus shows inverted values so stale data never looks valid
	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] wd,
			output logic [15:0] d, output logic v, output logic e);
		@(posedge clk_sys_i);
		req_o <= '{rd_en: ~wr, wr_en: wr, addr: a, wdata: wd};
		@(posedge clk_sys_i);
		req_o <= '{rd_en: 1'b0, wr_en: 1'b0, addr: ~a, wdata: ~wd};
		@(posedge clk_sys_i);
		d = rd_data_i;
		v = rd_valid_i;
		e = access_err_i;
	endtask : access
endmodule : wlr_bus_master
